// file: src/ascp_pkg.sv
package ascp_pkg;
   // Configuration word layout
   localparam int CFG_W = 16;
   localparam int DATA_W = 24;
   localparam int QUAL_HI = 2;
   localparam int QUAL_LO = 1;
   localparam int PULLUP_BIT = 3;
   localparam int RSVD4_BIT = 4;
   localparam int RSVD0_BIT = 0;
   localparam logic [1:0] QUAL_VALID = 2'h1;
   localparam logic [15:0] CFG_RESET = 16'h058b;
   localparam logic RSVD4_VALUE = 1'h0;
   localparam logic RSVD0_VALUE = 1'h1;
   // Timing
   localparam int CLK_HZ = 25000000;
   localparam int TIMEOUT_MS = 28;
   localparam longint TIMEOUT_CYC_L = (longint'(CLK_HZ) * TIMEOUT_MS) / 1000;
   localparam int TIMEOUT_CYC = int'(TIMEOUT_CYC_L);
   localparam int TMO_W = 20;
   localparam int CNT_W = 5;

   typedef struct packed {
      logic oe;
      logic out;
      logic pullup_en;
   } ascp_pin_t;
endpackage : ascp_pkg

// file: src/ascp_sync.sv
`timescale 1ns/10ps
module ascp_sync (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Asynchronous level in, synchronised level out
   input wire logic d,
   output logic q
);
   typedef struct packed {
      logic s1;
      logic s2;
   } ascp_sync_t;

   ascp_sync_t st;
   ascp_sync_t next_st;

   always_comb begin
      next_st.s1 = d;
      next_st.s2 = st.s1;
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign q = st.s2;
endmodule : ascp_sync

// file: src/ascp_port.sv
`timescale 1ns/10ps
// What this block does
// - Configuration updates only when the write-qualifier field of the shifted word is 01.
// - Bit 3 enables the weak pull-up on the out/ready pin; resets to 1.
// - Reserved bits 4 and 0 ignore writes; bit 4 reads 0, bit 0 reads 1.
// - Serial framing is mode 1, clock polarity zero, clock phase one.
// - Clock idles low; outputs change on rising, inputs sampled on falling edges.
// - Abort the current transfer when serial clock stays low longer than 28 ms.
// - Pull-up enabled: stop driving pin, pull-up holds it high while select is high.
// - Pull-up disabled: pin goes high impedance when select is high.
// - On select low drive pin at once: low if fresh result waits, else high.
// - Result finishing mid-transfer waits for the next transfer; shifted data stays intact.
module ascp_port #(
   parameter int TIMEOUT_CYCLES = ascp_pkg::TIMEOUT_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Serial pins
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic din,
   output logic serial_out_ready_pin_o,
   output logic serial_out_ready_pin_oe,
   output logic pullup_en,
   // Converter core side
   input wire logic [23:0] conv_data,
   input wire logic conv_done,
   output logic [15:0] configuration_word,
   output logic cfg_written
);
   ////////////////////////////////////////////////////////////////////////
   typedef enum logic [1:0] {IDLE, ACTIVE, ABORTED} ascp_state_e;

   typedef struct packed {
      ascp_state_e state;
      logic sclk_d;
      logic [23:0] result;
      logic fresh;
      logic [23:0] shift_out;
      logic [15:0] shift_in;
      logic [4:0] bit_cnt;
      logic [19:0] low_cnt;
      logic [15:0] cfg;
      logic cfg_written;
      logic pin_out;
      logic pin_oe;
   } ascp_st_t;

   ascp_st_t st;
   ascp_st_t next_st;
   logic sclk_s;
   logic cs_n_s;
   logic cs_s;
   logic din_s;
   logic rise;
   logic fall;
   logic [15:0] word;

   // Declared before the state logic that compares against it
   localparam logic [19:0] TMO_MAX = 20'(TIMEOUT_CYCLES);

   ////////////////////////////////////////////////////////////////////////
   // Pins come from the host's domain; two flops each
   ascp_sync u_sync_sclk (.clk(clk), .reset_n(reset_n), .d(sclk), .q(sclk_s));
   // Select synchronised active high, so the flops reset to deselected, not to a false select
   ascp_sync u_sync_cs (.clk(clk), .reset_n(reset_n), .d(~cs_n), .q(cs_s));
   assign cs_n_s = ~cs_s;
   ascp_sync u_sync_din (.clk(clk), .reset_n(reset_n), .d(din), .q(din_s));

   assign rise = sclk_s & ~st.sclk_d;
   assign fall = ~sclk_s & st.sclk_d;
   assign word = {st.shift_in[14:0], din_s};

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_st = st;
      next_st.sclk_d = sclk_s;
      next_st.cfg_written = 1'b0;
      // Result capture; a finished conversion never touches shift_out
      if (conv_done) begin
         next_st.result = conv_data;
         next_st.fresh = 1'b1;
      end
      unique case (st.state)
         IDLE: begin
            if (!cs_n_s) begin
               next_st.state = ACTIVE;
               next_st.shift_out = st.result;
               next_st.fresh = conv_done; // Set wins over the read clear
               next_st.bit_cnt = '0;
               next_st.low_cnt = '0;
               next_st.shift_in = '0;
               next_st.pin_oe = 1'b1;
               next_st.pin_out = ~st.fresh;
            end
         end
         ACTIVE: begin
            if (cs_n_s) begin
               next_st.state = IDLE;
            end else begin
               if (sclk_s) begin
                  next_st.low_cnt = '0;
               end else if (st.low_cnt >= TMO_MAX) begin
                  next_st.state = ABORTED;
                  next_st.shift_in = '0;
                  next_st.bit_cnt = '0;
               end else begin
                  next_st.low_cnt = st.low_cnt + 20'h00001;
               end
               if (rise) begin
                  // Mode 1: put next bit out on the rising edge
                  next_st.pin_out = st.shift_out[ascp_pkg::DATA_W-1];
                  next_st.shift_out = {st.shift_out[ascp_pkg::DATA_W-2:0], 1'b0};
               end
               if (fall) begin
                  next_st.shift_in = word;
                  next_st.bit_cnt = st.bit_cnt + 5'h01;
                  if (st.bit_cnt == 5'(ascp_pkg::CFG_W - 1)) begin
                     // Host holding din steady gives 00 or 11, so no write
                     if (word[ascp_pkg::QUAL_HI:ascp_pkg::QUAL_LO] == ascp_pkg::QUAL_VALID) begin
                        next_st.cfg = word;
                        next_st.cfg[ascp_pkg::RSVD4_BIT] = ascp_pkg::RSVD4_VALUE;
                        next_st.cfg[ascp_pkg::RSVD0_BIT] = ascp_pkg::RSVD0_VALUE;
                        next_st.cfg_written = 1'b1;
                     end
                  end
               end
            end
         end
         ABORTED: begin
            // Wait for select to rise before a new transfer
            if (cs_n_s) begin
               next_st.state = IDLE;
            end
         end
         // Two state bits leave one code unused; recover to idle
         default: begin
            next_st.state = IDLE;
         end
      endcase
      if (cs_n_s) begin
         next_st.pin_oe = 1'b0;
         next_st.pin_out = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st.state <= IDLE;
         st.sclk_d <= 1'b0;
         st.result <= '0;
         st.fresh <= 1'b0;
         st.shift_out <= '0;
         st.shift_in <= '0;
         st.bit_cnt <= '0;
         st.low_cnt <= '0;
         st.cfg <= ascp_pkg::CFG_RESET;
         st.cfg_written <= 1'b0;
         st.pin_out <= 1'b0;
         st.pin_oe <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   assign serial_out_ready_pin_o = st.pin_out;
   assign serial_out_ready_pin_oe = st.pin_oe;
   assign pullup_en = st.cfg[ascp_pkg::PULLUP_BIT];
   assign configuration_word = st.cfg;
   assign cfg_written = st.cfg_written;
endmodule : ascp_port

// file: tb/ascp_host.sv
`timescale 1ns/10ps
module ascp_host (
   // Link pins
   input wire logic clk,
   input wire logic pin,
   output logic sclk,
   output logic cs_n,
   output logic din
);
   initial begin
      sclk = 1'h0;
      cs_n = 1'h1;
      din = 1'h0;
   end
   task automatic half(input int n);
      repeat (n) @(negedge clk);
   endtask : half
   // A stall overruns the clock-low limit on purpose
   task automatic xfer(input logic [15:0] w, input logic stall, output logic [23:0] rd, output logic rdy);
      cs_n <= 1'h0;
      half(4);
      rdy = pin;
      for (int i = 0; i < 24; i++) begin
         sclk <= 1'h1;
         if (i < 16) din <= w[15 - i];
         half(4);
         rd = {rd[22:0], pin};
         sclk <= 1'h0;
         half(stall && i == 7 ? 300 : 4);
      end
      cs_n <= 1'h1;
      half(4);
   endtask : xfer
endmodule : ascp_host

// file: tb/ascp_props.sv
`timescale 1ns/10ps
module ascp_props #(
   parameter int TIMEOUT_CYCLES = 200
) (
   // Watched ports
   input wire logic clk,
   input wire logic reset_n,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic serial_out_ready_pin_o,
   input wire logic serial_out_ready_pin_oe,
   input wire logic pullup_en,
   input wire logic [15:0] configuration_word,
   input wire logic cfg_written
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   // Saturates past the limit, so it stays set until deselect
   int low_cnt;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) low_cnt <= 0;
      else if (cs_n || (sclk && low_cnt <= TIMEOUT_CYCLES)) low_cnt <= 0;
      else if (low_cnt <= TIMEOUT_CYCLES) low_cnt <= low_cnt + 1;
   end
   sequence sel_s; $fell(cs_n) ##1 !cs_n [*5]; endsequence
   sequence quiet_s; (!sclk && !cs_n) [*8]; endsequence
   rsvd_bits_a:
      assert property (configuration_word[4] == 1'h0 && configuration_word[0] == 1'h1) else $error("reserved bit");
   pullup_map_a:
      assert property (pullup_en == configuration_word[3]) else $error("pull-up enable");
   qual_gate_a:
      assert property (cfg_written |-> configuration_word[2:1] == 2'h1) else $error("qualifier");
   write_cause_a:
      assert property ($changed(configuration_word) |-> ##[0:1] cfg_written) else $error("silent write");
   release_pin_a:
      assert property (cs_n [*5] |-> !serial_out_ready_pin_oe) else $error("pin not released");
   drive_pin_a:
      assert property (sel_s |-> serial_out_ready_pin_oe) else $error("pin not driven");
   data_hold_a:
      assert property (quiet_s |-> $stable(serial_out_ready_pin_o)) else $error("data moved");
   timeout_a:
      assert property (low_cnt > TIMEOUT_CYCLES |-> !cfg_written) else $error("write after abort");
endmodule : ascp_props
bind ascp_port ascp_props #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_props (.clk(clk), .reset_n(reset_n),
   .sclk(sclk), .cs_n(cs_n), .serial_out_ready_pin_o(serial_out_ready_pin_o),
   .serial_out_ready_pin_oe(serial_out_ready_pin_oe), .pullup_en(pullup_en),
   .configuration_word(configuration_word), .cfg_written(cfg_written));

// file: tb/test_adc_serial_config_port.sv
`timescale 1ns/10ps
module test_adc_serial_config_port;
   logic clk = 1'h0;
   logic reset_n = 1'h0;
   logic done = 1'h0;
   logic [23:0] data = 24'ha5c3e1;
   wire sclk, cs_n, din, po, poe, pu, wr;
   wire [15:0] cfg;
   wire pin = poe ? po : (pu ? 1'h1 : 1'hz);
   int failures = 0;
   int tests_run = 0;
   logic [23:0] rd;
   logic rdy;
   // Word sent, config expected, ready level expected
   logic [32:0] rows [5] = '{{16'h8e3b, 16'h8e2b, 1'h0}, {16'h1234, 16'h8e2b, 1'h1},
      {16'hffff, 16'h8e2b, 1'h1}, {16'h0000, 16'h8e2b, 1'h1}, {16'h4072, 16'h4063, 1'h1}};
   always #20 clk = ~clk;
   ascp_port #(.TIMEOUT_CYCLES(200)) u_dut (.clk(clk), .reset_n(reset_n), .sclk(sclk), .cs_n(cs_n),
      .din(din), .serial_out_ready_pin_o(po), .serial_out_ready_pin_oe(poe), .pullup_en(pu),
      .conv_data(data), .conv_done(done), .configuration_word(cfg), .cfg_written(wr));
   ascp_host u_host (.clk(clk), .pin(pin), .sclk(sclk), .cs_n(cs_n), .din(din));
   task automatic chk(input logic ok, input string m);
      tests_run++;
      if (ok !== 1'h1) begin
         failures++;
         $display("MISMATCH %0t %s", $time, m);
      end
   endtask : chk
   task automatic conclude;
      $display("checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : conclude
   task automatic pulse(input logic [23:0] d);
      data <= d;
      done <= 1'h1;
      @(negedge clk);
      done <= 1'h0;
   endtask : pulse
   initial begin
      #200us;
      failures++;
      conclude();
   end
   initial begin
      repeat (4) @(negedge clk);
      reset_n <= 1'h1;
      repeat (4) @(negedge clk);
      chk(cfg === ascp_pkg::CFG_RESET && pin === 1'h1, "reset");
      pulse(24'ha5c3e1);
      for (int i = 0; i < 5; i++) begin
         u_host.xfer(rows[i][32:17], 1'h0, rd, rdy);
         repeat (4) @(negedge clk);
         chk(cfg === rows[i][16:1], "config");
         chk(rdy === rows[i][0] && rd === 24'ha5c3e1, "result");
         $display("row %0d done", i);
      end
      chk(pin === 1'hz, "float");
      u_host.xfer(16'h8e3b, 1'h1, rd, rdy);
      chk(cfg === 16'h4063, "abort");
      fork
         u_host.xfer(16'h0000, 1'h0, rd, rdy);
         begin
            repeat (60) @(negedge clk);
            pulse(24'h3c5a69);
         end
      join
      chk(rd === 24'ha5c3e1, "torn");
      u_host.xfer(16'h0000, 1'h0, rd, rdy);
      chk(rdy === 1'h0 && rd === 24'h3c5a69, "late");
      $display("tail done");
      conclude();
   end
endmodule : test_adc_serial_config_port
